// [rtl/clkbuf_defs.svh]
// Constants for the clock buffer SMBus configuration target
`ifndef CLKBUF_DEFS_SVH
`define CLKBUF_DEFS_SVH

// =====================================================
// Bus addressing
`define SMB_TARGET_ADDR 7'h6d
`define SMB_BYTE_BITS 4'h8
`define SMB_TX_LAST_BIT 4'h7
`define SMB_READ_COUNT 8'h03
`define SMB_REG_COUNT 8'h03

// =====================================================
// Register offsets
`define REG_OUTPUT_ENABLE_CTRL 8'h00
`define REG_PLL_MODE_AND_SWING_CTRL 8'h01
`define REG_OUTPUT_EDGE_RATE_CTRL 8'h02

// =====================================================
// Reset values and writable bits
`define REG0_RESET 8'h39
`define REG1_RESET 8'h06
`define REG2_RESET 8'hb9
`define REG0_WMASK 8'h28
`define REG1_WMASK 8'h3b
`define REG2_WMASK 8'h28

// =====================================================
// Field positions
`define OUT1_ENABLE_BIT 5
`define OUT0_ENABLE_BIT 3
`define PLL_MODE_SW_SELECT_BIT 5
`define PLL_MODE_CTRL_HI 4
`define PLL_MODE_CTRL_LO 3
`define AMPLITUDE_HI 1
`define AMPLITUDE_LO 0
`define OUT1_EDGE_RATE_SEL 5
`define OUT0_EDGE_RATE_SEL 3

// =====================================================
// Strap capture delay after reset release
`define STRAP_SETTLE 2'h3

`endif

// [rtl/clkbuf_pkg.sv]
// Types shared by the clock buffer SMBus target
package clkbuf_pkg;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } smb_state_t;

  typedef enum logic [1:0] {
    PH_INDEX = 2'h0,
    PH_COUNT = 2'h1,
    PH_DATA  = 2'h2
  } wr_phase_t;

endpackage

// [rtl/smbus_line_sync.sv]
// Synchroniser and condition detector for the SMBus clock and data pins
`timescale 1ns/1ps
`default_nettype none

module smbus_line_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Detected events
  output logic sda_level,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  // =====================================================
  // Two-stage sync, then one history stage for edges
  logic [1:0] scl_reg, scl_next;
  logic [1:0] sda_reg, sda_next;
  logic scl_prev_reg, scl_prev_next;
  logic sda_prev_reg, sda_prev_next;

  always_comb begin
    scl_next = {scl_reg[0], scl_pin};
    sda_next = {sda_reg[0], sda_pin};
    scl_prev_next = scl_reg[1];
    sda_prev_next = sda_reg[1];
  end

  // Idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_reg <= 2'h3;
      sda_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  assign sda_level = sda_reg[1];
  assign scl_rise = scl_reg[1] && !scl_prev_reg;
  assign scl_fall = !scl_reg[1] && scl_prev_reg;
  assign start_seen = scl_reg[1] && scl_prev_reg && sda_prev_reg && !sda_reg[1];
  assign stop_seen = scl_reg[1] && scl_prev_reg && !sda_prev_reg && sda_reg[1];

endmodule
`default_nettype wire

// [rtl/clk_output_ctrl.sv]
// Registered control of the two differential clock outputs
`timescale 1ns/1ps
`default_nettype none

module clk_output_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Active-low enable pins
  input wire logic [1:0] out_en_n,
  // Register fields
  input wire logic [1:0] reg_enable,
  input wire logic [1:0] reg_edge_fast,
  input wire logic [1:0] reg_amplitude,
  input wire logic pll_mode_sw_select,
  input wire logic [1:0] pll_mode_ctrl,
  input wire logic [1:0] pll_mode_readback,
  // Output controls
  output logic [1:0] out_run,
  output logic [1:0] out_edge_fast,
  output logic [1:0] out_amplitude,
  output logic [1:0] pll_mode
);
  // =====================================================
  // Pin sync and output registers
  logic [1:0] oe_meta_reg, oe_meta_next;
  logic [1:0] oe_sync_reg, oe_sync_next;
  logic [1:0] run_next, edge_next, amp_next, mode_next;

  always_comb begin
    oe_meta_next = out_en_n;
    oe_sync_next = oe_meta_reg;
    run_next = reg_enable & ~oe_sync_reg;
    edge_next = reg_edge_fast;
    amp_next = reg_amplitude;
    mode_next = pll_mode_sw_select ? pll_mode_ctrl : pll_mode_readback;
  end

  // Pins reset to disabled so outputs stay low until the sync fills
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oe_meta_reg <= 2'h3;
      oe_sync_reg <= 2'h3;
      out_run <= 2'h0;
      out_edge_fast <= 2'h3;
      out_amplitude <= 2'h2;
      pll_mode <= 2'h0;
    end else begin
      oe_meta_reg <= oe_meta_next;
      oe_sync_reg <= oe_sync_next;
      out_run <= run_next;
      out_edge_fast <= edge_next;
      out_amplitude <= amp_next;
      pll_mode <= mode_next;
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_force_low;
    !reg_enable[0] |=> !out_run[0];
  endproperty
  a_force_low: assert property (p_force_low) else $error("disabled output ran");

  property p_run_follows;
    (reg_enable[1] && !oe_sync_reg[1]) |=> out_run[1];
  endproperty
  a_run_follows: assert property (p_run_follows) else $error("enabled output idle");

  property p_mode_source;
    ##1 pll_mode == ($past(pll_mode_sw_select) ? $past(pll_mode_ctrl) : $past(pll_mode_readback));
  endproperty
  a_mode_source: assert property (p_mode_source) else $error("wrong PLL mode source");

  property p_edge_rate;
    ##1 out_edge_fast == $past(reg_edge_fast);
  endproperty
  a_edge_rate: assert property (p_edge_rate) else $error("edge rate mismatch");

  c_sw_mode: cover property (pll_mode_sw_select && pll_mode != pll_mode_readback);

endmodule
`default_nettype wire

// [rtl/clkbuf_smbus_target.sv]
// SMBus configuration target of a two-output clock buffer
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_defs.svh"

// Operation
// - The target answers only to address 1101101 with the last bit as direction, 0 write 1 read.
// - A write starts with start and the write address, which the target acknowledges.
// - The host then sends the start index, which the target acknowledges.
// - In a block write the host next sends a byte count, which the target acknowledges.
// - The following data bytes go to index onward in order, each acknowledged and stored up to the byte count.
// - A block read repeats start after the index and sends the read address, which is acknowledged.
// - After the read address the target sends the byte count then registers from the index upward.
// - Byte 0 bits 5 and 3 enable outputs 1 and 0; zero holds both legs low.
// - A cleared enable bit forces its output low whatever its active-low enable pin says.
// - Byte 1 bits 7:6 read back the PLL mode latched from the strap input.
// - Byte 1 bit 5, reset 0, selects the strap mode when 0 and software bits 4:3 when 1.
// - Software mode bits 4:3 have no effect unless byte 1 bit 5 is set.
// - Byte 2 bits 5 and 3 pick slow (0) or fast (1) edges for outputs 1 and 0, reset fast.
module clkbuf_smbus_target (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // SMBus pins, data is open drain
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  // Device pins
  input wire logic [1:0] out_en_n,
  input wire logic [1:0] pll_mode_strap,
  // Clock path controls
  output logic [1:0] out_run,
  output logic [1:0] out_edge_fast,
  output logic [1:0] out_amplitude,
  output logic [1:0] pll_mode
);
  import clkbuf_pkg::*;

  // =====================================================
  // Line conditioning
  logic sda_level, scl_rise, scl_fall, start_seen, stop_seen;

  smbus_line_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .scl_pin(smb_clk_in),
    .sda_pin(smb_data_in),
    .sda_level(sda_level),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // =====================================================
  // Strap capture
  logic [1:0] strap_meta_reg, strap_meta_next;
  logic [1:0] strap_sync_reg, strap_sync_next;
  logic [1:0] readback_reg, readback_next;
  logic [1:0] settle_reg, settle_next;
  logic strap_done_reg, strap_done_next;

  // Captured a few cycles after release so the sync holds the real level
  always_comb begin
    strap_meta_next = pll_mode_strap;
    strap_sync_next = strap_meta_reg;
    settle_next = settle_reg;
    strap_done_next = strap_done_reg;
    readback_next = readback_reg;
    if (!strap_done_reg) begin
      if (settle_reg == `STRAP_SETTLE) begin
        readback_next = strap_sync_reg;
        strap_done_next = 1'b1;
      end else begin
        settle_next = settle_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
      readback_reg <= 2'h0;
      settle_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_meta_reg <= strap_meta_next;
      strap_sync_reg <= strap_sync_next;
      readback_reg <= readback_next;
      settle_reg <= settle_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // =====================================================
  // Register file
  localparam logic [7:0] REG_RESET [3] = '{`REG0_RESET, `REG1_RESET, `REG2_RESET};
  localparam logic [7:0] REG_WMASK [3] = '{`REG0_WMASK, `REG1_WMASK, `REG2_WMASK};
  logic [7:0] regs_reg [3];
  logic [7:0] regs_next [3];
  logic wr_stb;
  logic [7:0] index_reg, index_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] rd_byte;

  for (genvar g = 0; g < 3; g++) begin : g_reg
    always_comb begin
      regs_next[g] = regs_reg[g];
      if (wr_stb && index_reg == 8'(g)) begin
        regs_next[g] = (regs_reg[g] & ~REG_WMASK[g]) | (shift_reg & REG_WMASK[g]);
      end
    end
    always_ff @(posedge core_clk) begin
      if (reset) begin
        regs_reg[g] <= REG_RESET[g];
      end else begin
        regs_reg[g] <= regs_next[g];
      end
    end
  end

  // Unmapped indices read as zero
  always_comb begin
    unique case (index_reg)
      `REG_OUTPUT_ENABLE_CTRL: rd_byte = regs_reg[0];
      `REG_PLL_MODE_AND_SWING_CTRL: rd_byte = {readback_reg, regs_reg[1][5:0]};
      `REG_OUTPUT_EDGE_RATE_CTRL: rd_byte = regs_reg[2];
      default: rd_byte = 8'h00;
    endcase
  end

  // =====================================================
  // Protocol engine
  smb_state_t state_reg, state_next;
  wr_phase_t phase_reg, phase_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] remain_reg, remain_next;
  logic rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic oe_next;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    index_next = index_reg;
    remain_next = remain_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    oe_next = smb_data_oe;
    wr_stb = 1'b0;
    if (stop_seen) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_seen) begin
      state_next = ST_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_level};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == `SMB_BYTE_BITS) begin
            if (shift_reg[7:1] == `SMB_TARGET_ADDR) begin
              state_next = ST_ADDR_ACK;
              oe_next = 1'b1;
              rd_next = shift_reg[0];
              if (!shift_reg[0]) begin
                phase_next = PH_INDEX;
              end
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (rd_reg) begin
              state_next = ST_TX;
              shift_next = `SMB_READ_COUNT;
              oe_next = !shift_next[7];
            end else begin
              state_next = ST_RX;
              oe_next = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_level};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == `SMB_BYTE_BITS) begin
            state_next = ST_RX_ACK;
            oe_next = 1'b1;
            unique case (phase_reg)
              PH_INDEX: begin
                index_next = shift_reg;
                phase_next = PH_COUNT;
              end
              PH_COUNT: begin
                remain_next = shift_reg;
                phase_next = PH_DATA;
              end
              default: begin
                // Bytes past the announced count are acknowledged but dropped
                if (remain_reg != 8'h00) begin
                  wr_stb = 1'b1;
                  index_next = index_reg + 8'h01;
                  remain_next = remain_reg - 8'h01;
                end
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            state_next = ST_RX;
            oe_next = 1'b0;
            bit_next = 4'h0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_reg == `SMB_TX_LAST_BIT) begin
              state_next = ST_TX_ACK;
              oe_next = 1'b0;
              bit_next = 4'h0;
            end else begin
              bit_next = bit_reg + 4'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = !shift_reg[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_next = !sda_level;
          end else if (scl_fall) begin
            if (ack_reg) begin
              state_next = ST_TX;
              shift_next = rd_byte;
              index_next = index_reg + 8'h01;
              oe_next = !rd_byte[7];
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_INDEX;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      index_reg <= 8'h00;
      remain_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      smb_data_oe <= 1'b0;
      smb_data_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      index_reg <= index_next;
      remain_reg <= remain_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      smb_data_oe <= oe_next;
      smb_data_out <= 1'b0;
    end
  end

  // =====================================================
  // Output path
  clk_output_ctrl u_out (
    .core_clk(core_clk),
    .reset(reset),
    .out_en_n(out_en_n),
    .reg_enable({regs_reg[0][`OUT1_ENABLE_BIT], regs_reg[0][`OUT0_ENABLE_BIT]}),
    .reg_edge_fast({regs_reg[2][`OUT1_EDGE_RATE_SEL], regs_reg[2][`OUT0_EDGE_RATE_SEL]}),
    .reg_amplitude({regs_reg[1][`AMPLITUDE_HI], regs_reg[1][`AMPLITUDE_LO]}),
    .pll_mode_sw_select(regs_reg[1][`PLL_MODE_SW_SELECT_BIT]),
    .pll_mode_ctrl({regs_reg[1][`PLL_MODE_CTRL_HI], regs_reg[1][`PLL_MODE_CTRL_LO]}),
    .pll_mode_readback(readback_reg),
    .out_run(out_run),
    .out_edge_fast(out_edge_fast),
    .out_amplitude(out_amplitude),
    .pll_mode(pll_mode)
  );

  // =====================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic addr_done;
  assign addr_done = state_reg == ST_ADDR && scl_fall && bit_reg == `SMB_BYTE_BITS
                     && !stop_seen && !start_seen;

  property p_addr_ack;
    (addr_done && shift_reg[7:1] == `SMB_TARGET_ADDR) |=> state_reg == ST_ADDR_ACK && smb_data_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_foreign;
    (addr_done && shift_reg[7:1] != `SMB_TARGET_ADDR) |=> state_reg == ST_IDLE && !smb_data_oe;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");

  property p_idle_no_write;
    state_reg == ST_IDLE |=> $stable(regs_reg[0]) && $stable(regs_reg[1]) && $stable(regs_reg[2]);
  endproperty
  a_idle_no_write: assert property (p_idle_no_write) else $error("register changed while idle");

  property p_index_ack;
    (state_reg == ST_RX && phase_reg == PH_INDEX && scl_fall && bit_reg == `SMB_BYTE_BITS
     && !stop_seen && !start_seen) |=> index_reg == $past(shift_reg) && smb_data_oe;
  endproperty
  a_index_ack: assert property (p_index_ack) else $error("index byte mishandled");

  property p_count_ack;
    (state_reg == ST_RX && phase_reg == PH_COUNT && scl_fall && bit_reg == `SMB_BYTE_BITS
     && !stop_seen && !start_seen) |=> remain_reg == $past(shift_reg) && smb_data_oe;
  endproperty
  a_count_ack: assert property (p_count_ack) else $error("count byte mishandled");

  property p_data_store;
    wr_stb |=> index_reg == $past(index_reg) + 8'h01 && smb_data_oe && state_reg == ST_RX_ACK;
  endproperty
  a_data_store: assert property (p_data_store) else $error("data byte not stored");

  property p_read_count;
    (state_reg == ST_ADDR_ACK && rd_reg && scl_fall && !stop_seen && !start_seen)
      |=> state_reg == ST_TX && shift_reg == `SMB_READ_COUNT;
  endproperty
  a_read_count: assert property (p_read_count) else $error("read did not start with count");

  property p_readback_hold;
    strap_done_reg |=> $stable(readback_reg);
  endproperty
  a_readback_hold: assert property (p_readback_hold) else $error("mode readback changed");

  c_write: cover property (wr_stb);
  c_read: cover property (state_reg == ST_TX_ACK && scl_fall && ack_reg);
  c_foreign: cover property (addr_done && shift_reg[7:1] != `SMB_TARGET_ADDR);
  c_nack_end: cover property (state_reg == ST_TX_ACK && scl_fall && !ack_reg);

endmodule
`default_nettype wire

// [verification/smb_host_model.sv]
// Behavioural SMBus host that issues indexed block transfers
`timescale 1ns/1ps
`default_nettype none

module smb_host_model (
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // =====================================================
  // Bus idle: clock held high by pull-up, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Start and repeated start share one sequence
  task automatic start();
    sda_low <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b1;
    tick(10);
    scl <= 1'b0;
    tick(5);
  endtask

  // Stop closes every transfer
  task automatic stop();
    sda_low <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b0;
    tick(10);
  endtask

  // Ten cycles per clock phase, data changes mid-low to keep setup and hold
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    s = sda_in;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask

  // MSB first byte, then a released bit to sample the ACK
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // ACK every byte but the last, NACK the last one
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the clock buffer SMBus target
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_defs.svh"

module tb_top;
  import clkbuf_pkg::*;
  logic core_clk, reset, scl, host_low, sda, smb_data_out, smb_data_oe, ack;
  logic [1:0] out_en_n, strap, out_run, out_edge_fast, out_amplitude, pll_mode;
  logic [7:0] d;
  int n_fail, n_tests, cyc;

  // Open-drain data wire with pull-up; the target only ever drives low
  assign sda = host_low ? 1'b0 : (smb_data_oe ? smb_data_out : 1'b1);

  clkbuf_smbus_target dut (
    .core_clk(core_clk), .reset(reset), .smb_clk_in(scl), .smb_data_in(sda),
    .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .out_en_n(out_en_n),
    .pll_mode_strap(strap), .out_run(out_run), .out_edge_fast(out_edge_fast),
    .out_amplitude(out_amplitude), .pll_mode(pll_mode)
  );

  smb_host_model host (.core_clk(core_clk), .sda_in(sda), .scl(scl), .sda_low(host_low));

  // =====================================================
  // Clock and timeout
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Tests need about 8k cycles; ceiling leaves generous margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  // =====================================================
  // Checking and bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [15:0] dd,
                    input int x, input logic ack_exp);
    host.start();
    host.put({a, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, ack_exp});
    if (ack_exp) begin
      host.put(n, ack);
      chk({7'h00, ack}, 8'h01);
      host.put(x[7:0], ack);
      chk({7'h00, ack}, 8'h01);
      for (int i = 0; i < x; i++) begin
        host.put(dd[15-8*i -: 8], ack);
        chk({7'h00, ack}, 8'h01);
      end
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] n, input int x, input logic [23:0] e);
    host.start();
    host.put(8'hda, ack);
    chk({7'h00, ack}, 8'h01);
    host.put(n, ack);
    chk({7'h00, ack}, 8'h01);
    host.start();
    host.put(8'hdb, ack);
    chk({7'h00, ack}, 8'h01);
    host.get(1'b0, d);
    chk(d, `SMB_READ_COUNT);
    for (int i = 0; i < x; i++) begin
      host.get(i == x - 1, d);
      chk(d, e[23-8*i -: 8]);
    end
    host.stop();
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // =====================================================
  // Test sequence
  initial begin
    reset = 1'b1;
    out_en_n = 2'b11;
    strap = 2'b10;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    // Reset values with strap readback in byte 1
    rd(8'h00, 3, 24'h39_86_b9);
    chk({6'h00, out_edge_fast}, 8'h03);
    chk({6'h00, out_amplitude}, 8'h02);
    chk({6'h00, pll_mode}, 8'h02);
    chk({6'h00, out_run}, 8'h00);
    $display("test reset done");
    // Strap moves after the latch, so readback and mode must keep the old value
    strap <= 2'h1;
    // Enable pins against register override
    out_en_n <= 2'b10;
    repeat (8) @(posedge core_clk);
    chk({6'h00, out_run}, 8'h01);
    out_en_n <= 2'b00;
    wr(7'h6d, 8'h00, 16'h0800, 1, 1'b1);
    chk({6'h00, out_run}, 8'h01);
    wr(7'h6d, 8'h00, 16'hd700, 1, 1'b1);
    chk({6'h00, out_run}, 8'h00);
    rd(8'h00, 1, 24'h11_00_00);
    $display("test enables done");
    // Software mode bits ignored until select is set
    wr(7'h6d, 8'h01, 16'h1b00, 2, 1'b1);
    chk({6'h00, pll_mode}, 8'h02);
    chk({6'h00, out_amplitude}, 8'h03);
    chk({6'h00, out_edge_fast}, 8'h00);
    rd(8'h01, 2, 24'h9f_91_00);
    wr(7'h6d, 8'h01, 16'h3b00, 1, 1'b1);
    chk({6'h00, pll_mode}, 8'h03);
    $display("test pll mode done");
    // Foreign address: no ACK, nothing changes
    wr(7'h6c, 8'h00, 16'hff00, 1, 1'b0);
    rd(8'h00, 2, 24'h11_bf_00);
    chk({6'h00, out_run}, 8'h00);
    $display("test foreign address done");
    results();
  end
endmodule

`default_nettype wire
